// >>> design/mic_map.vh
// Register map, field positions, reset values and vectors of the interrupt controller
`ifndef MIC_MAP_VH
`define MIC_MAP_VH
// Byte offsets on the AHB-Lite bus
`define MIC_OFS_INTERRUPT_FLAGS_ENABLES_FIRST 8'h00
`define MIC_OFS_INTERRUPT_FLAGS_ENABLES_SECOND 8'h04
`define MIC_OFS_EDGE 8'h08
`define MIC_OFS_TBC 8'h0C
`define MIC_OFS_STAT 8'h10
// First interrupt register fields
`define MIC_C0_GIE 0
`define MIC_C0_EXTE 1
`define MIC_C0_D2 2
`define MIC_C0_CNTE 3
`define MIC_C0_EXTF 4
`define MIC_C0_D5 5
`define MIC_C0_CNTF 6
// Second interrupt register fields
`define MIC_C1_TICKE 0
`define MIC_C1_BUFE 1
`define MIC_C1_RELE 2
`define MIC_C1_TICKF 4
`define MIC_C1_BUFF 5
`define MIC_C1_RELF 6
// Time-base control fields
`define MIC_TBC_RUN 7
`define MIC_TBC_SEL_HI 2
// Edge select encodings
`define MIC_EDGE_OFF 2'h0
`define MIC_EDGE_RISE 2'h1
`define MIC_EDGE_FALL 2'h2
`define MIC_EDGE_BOTH 2'h3
// Reset values
`define MIC_RST_INTERRUPT_FLAGS_ENABLES_FIRST 8'h00
`define MIC_RST_INTERRUPT_FLAGS_ENABLES_SECOND 8'h00
`define MIC_RST_EDGE 2'h0
`define MIC_RST_TBC 8'h00
// Vector addresses, one per source
`define MIC_VEC_EXT 12'h004
`define MIC_VEC_CNT 12'h008
`define MIC_VEC_TICK 12'h00C
`define MIC_VEC_BUF 12'h010
`define MIC_VEC_REL 12'h014
// Time-base divider: counter bit tapped for the smallest ratio, which is 2 to the power of this plus one
`define MIC_TB_BASE_EXP 4'h8
`endif

// >>> design/mic_irq_ctrl.v
// Interrupt controller with AHB-Lite registers, edge detector, time base and core vector hand-off
`timescale 1ns/10ps
`include "mic_map.vh"
module mic_irq_ctrl (
  // AHB-Lite slave
  input wire hclk,
  input wire hresetn,
  input wire hsel,
  input wire [7:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output wire hreadyout,
  output wire hresp,
  output reg [31:0] hrdata,
  // External pin and its pull-high selection
  input wire ext_pin_in,
  input wire ext_pin_pullhigh_sel,
  output wire ext_pin_pullhigh_en,
  // Peripheral events, one-cycle pulses
  input wire counter_overflow,
  input wire buf_empty_event,
  input wire reload_done_event,
  input wire sub_clock_tick,
  // Core sequencer
  input wire core_irq_ready,
  input wire [11:0] core_next_pc,
  input wire stack_full,
  input wire return_from_irq_instr,
  input wire [11:0] stack_pop_pc,
  input wire sleep_mode,
  output reg irq_take,
  output reg [11:0] irq_vector,
  output reg [11:0] irq_push_pc,
  output reg [11:0] resume_pc,
  output reg resume_valid,
  output reg wake_up
);

  localparam ST_RUN = 2'b01;
  localparam ST_TAKEN = 2'b10;

  reg [7:0] interrupt_flags_enables_first_reg;
  reg [7:0] interrupt_flags_enables_second_reg;
  reg [1:0] ext_edge_select_reg;
  reg [7:0] tbc_reg;
  reg tick_source_select_reg;
  reg [1:0] state_reg;
  reg [1:0] state_next;
  reg ext_pin_q_reg;
  reg [15:0] tick_div_reg;
  reg tick_tap_q_reg;
  reg [4:0] flags_q_reg;
  reg wr_pend_reg;
  reg [7:0] wr_addr_reg;

  wire global_irq_enable = interrupt_flags_enables_first_reg[`MIC_C0_GIE];
  wire ext_pin_irq_enable = interrupt_flags_enables_first_reg[`MIC_C0_EXTE];
  wire counter_irq_enable = interrupt_flags_enables_first_reg[`MIC_C0_CNTE];
  wire tick_irq_enable = interrupt_flags_enables_second_reg[`MIC_C1_TICKE];
  wire buf_empty_irq_enable = interrupt_flags_enables_second_reg[`MIC_C1_BUFE];
  wire reload_done_irq_enable = interrupt_flags_enables_second_reg[`MIC_C1_RELE];
  wire tick_run_enable = tbc_reg[`MIC_TBC_RUN];
  wire [2:0] tick_divide_select = tbc_reg[`MIC_TBC_SEL_HI:0];
  wire [1:0] ext_edge_select = ext_edge_select_reg;

  // Flag vector in priority order: ext, counter, tick, buffer, reload
  wire [4:0] flags = {interrupt_flags_enables_second_reg[`MIC_C1_RELF], interrupt_flags_enables_second_reg[`MIC_C1_BUFF], interrupt_flags_enables_second_reg[`MIC_C1_TICKF],
                      interrupt_flags_enables_first_reg[`MIC_C0_CNTF], interrupt_flags_enables_first_reg[`MIC_C0_EXTF]};
  wire [4:0] enables = {reload_done_irq_enable, buf_empty_irq_enable, tick_irq_enable,
                        counter_irq_enable, ext_pin_irq_enable};
  wire [4:0] pending = flags & enables;

  // Lowest set bit wins
  function [4:0] pick_first;
    input [4:0] req;
    begin
      pick_first = req & (~req + 5'h01);
    end
  endfunction

  function [11:0] vector_of;
    input [4:0] grant;
    begin
      case (grant)
        5'h01: vector_of = `MIC_VEC_EXT;
        5'h02: vector_of = `MIC_VEC_CNT;
        5'h04: vector_of = `MIC_VEC_TICK;
        5'h08: vector_of = `MIC_VEC_BUF;
        default: vector_of = `MIC_VEC_REL;
      endcase
    end
  endfunction

  wire [4:0] grant = pick_first(pending);
  wire take_now = (state_reg == ST_RUN) && global_irq_enable && (pending != 5'h00) &&
                  !stack_full && core_irq_ready;

  // External pin edge detection, active only with its enable set
  wire ext_rise = ext_pin_in & ~ext_pin_q_reg;
  wire ext_fall = ~ext_pin_in & ext_pin_q_reg;
  reg ext_event;
  always @* begin
    case (ext_edge_select)
      `MIC_EDGE_RISE: begin
        ext_event = ext_rise;
      end
      `MIC_EDGE_FALL: begin
        ext_event = ext_fall;
      end
      `MIC_EDGE_BOTH: begin
        ext_event = ext_rise | ext_fall;
      end
      default: begin
        ext_event = 1'b0;
      end
    endcase
    ext_event = ext_event & ext_pin_irq_enable;
  end
  assign ext_pin_pullhigh_en = ext_pin_pullhigh_sel;

  // Time base: clock from system or sub clock, power-of-two divide
  wire tick_clk_en = tick_source_select_reg ? sub_clock_tick : 1'b1;
  // Divider tap for the selected ratio
  function [3:0] tap_of;
    input [2:0] sel;
    begin
      tap_of = {1'b0, sel} + `MIC_TB_BASE_EXP;
    end
  endfunction

  wire [3:0] tap_idx = tap_of(tick_divide_select);
  wire tick_tap = tick_div_reg[tap_idx];
  wire tick_event = tick_run_enable & tick_tap_q_reg & ~tick_tap;

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tick_div_reg <= 16'h0000;
      tick_tap_q_reg <= 1'b0;
      ext_pin_q_reg <= 1'b0;
    end else begin
      ext_pin_q_reg <= ext_pin_in;
      tick_tap_q_reg <= tick_tap;
      if (!tick_run_enable) begin
        tick_div_reg <= 16'h0000;
      end else if (tick_clk_en) begin
        tick_div_reg <= tick_div_reg + 16'h0001;
      end
    end
  end

  // AHB-Lite slave: zero wait states, writes land in the data phase
  wire ahb_go = hsel && hready && htrans[1];
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  // Read word of the addressed register, unused bits zero
  reg [31:0] rd_word;
  always @* begin
    case (haddr)
      `MIC_OFS_INTERRUPT_FLAGS_ENABLES_FIRST: begin
        rd_word = {24'h000000, 1'b0, interrupt_flags_enables_first_reg[6:0]};
      end
      `MIC_OFS_INTERRUPT_FLAGS_ENABLES_SECOND: begin
        rd_word = {24'h000000, 1'b0, interrupt_flags_enables_second_reg[6:4], 1'b0, interrupt_flags_enables_second_reg[2:0]};
      end
      `MIC_OFS_EDGE: begin
        rd_word = {30'h00000000, ext_edge_select_reg};
      end
      `MIC_OFS_TBC: begin
        rd_word = {24'h000000, tbc_reg[7], 4'h0, tbc_reg[2:0]};
      end
      `MIC_OFS_STAT: begin
        rd_word = {23'h000000, tick_source_select_reg, 6'h00, state_reg};
      end
      default: begin
        rd_word = 32'h0000_0000;
      end
    endcase
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= 8'h00;
      hrdata <= 32'h0000_0000;
    end else begin
      wr_pend_reg <= ahb_go && hwrite;
      if (ahb_go) begin
        wr_addr_reg <= haddr;
      end
      if (ahb_go && !hwrite) begin
        hrdata <= rd_word;
      end
    end
  end

  // Write strobe for one register offset
  function wr_hit;
    input pend;
    input [7:0] addr;
    input [7:0] ofs;
    begin
      wr_hit = pend && (addr == ofs);
    end
  endfunction

  // Writes land at the end of the data phase
  wire wr0 = wr_hit(wr_pend_reg, wr_addr_reg, `MIC_OFS_INTERRUPT_FLAGS_ENABLES_FIRST);
  wire wr1 = wr_hit(wr_pend_reg, wr_addr_reg, `MIC_OFS_INTERRUPT_FLAGS_ENABLES_SECOND);
  wire wr_edge = wr_hit(wr_pend_reg, wr_addr_reg, `MIC_OFS_EDGE);
  wire wr_tbc = wr_hit(wr_pend_reg, wr_addr_reg, `MIC_OFS_TBC);
  wire wr_stat = wr_hit(wr_pend_reg, wr_addr_reg, `MIC_OFS_STAT);

  // Event vector in flag order
  wire [4:0] events = {reload_done_event, buf_empty_event, tick_event, counter_overflow, ext_event};
  wire [4:0] clr_take = take_now ? grant : 5'h00;

  reg [4:0] flags_next;
  integer i;
  always @* begin
    flags_next = flags;
    if (wr0) begin
      flags_next[0] = hwdata[`MIC_C0_EXTF];
      flags_next[1] = hwdata[`MIC_C0_CNTF];
    end
    if (wr1) begin
      flags_next[4:2] = {hwdata[`MIC_C1_RELF], hwdata[`MIC_C1_BUFF], hwdata[`MIC_C1_TICKF]};
    end
    // Event set wins over take clear and software clear
    for (i = 0; i < 5; i = i + 1) begin
      if (clr_take[i]) begin
        flags_next[i] = 1'b0;
      end
      if (events[i]) begin
        flags_next[i] = 1'b1;
      end
    end
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      interrupt_flags_enables_first_reg <= `MIC_RST_INTERRUPT_FLAGS_ENABLES_FIRST;
      interrupt_flags_enables_second_reg <= `MIC_RST_INTERRUPT_FLAGS_ENABLES_SECOND;
      ext_edge_select_reg <= `MIC_RST_EDGE;
      tbc_reg <= `MIC_RST_TBC;
      tick_source_select_reg <= 1'b0;
    end else begin
      if (wr0) begin
        interrupt_flags_enables_first_reg[`MIC_C0_EXTE] <= hwdata[`MIC_C0_EXTE];
        interrupt_flags_enables_first_reg[`MIC_C0_CNTE] <= hwdata[`MIC_C0_CNTE];
      end
      if (wr1) begin
        interrupt_flags_enables_second_reg[2:0] <= hwdata[2:0];
      end
      if (wr_edge) begin
        ext_edge_select_reg <= hwdata[1:0];
      end
      if (wr_tbc) begin
        tbc_reg <= {hwdata[7], 4'h0, hwdata[2:0]};
      end
      if (wr_stat) begin
        tick_source_select_reg <= hwdata[8];
      end
      // Global enable: take clears, return sets, else software
      if (take_now) begin
        interrupt_flags_enables_first_reg[`MIC_C0_GIE] <= 1'b0;
      end else if (return_from_irq_instr) begin
        interrupt_flags_enables_first_reg[`MIC_C0_GIE] <= 1'b1;
      end else if (wr0) begin
        interrupt_flags_enables_first_reg[`MIC_C0_GIE] <= hwdata[`MIC_C0_GIE];
      end
      {interrupt_flags_enables_first_reg[`MIC_C0_CNTF], interrupt_flags_enables_first_reg[`MIC_C0_EXTF]} <= flags_next[1:0];
      {interrupt_flags_enables_second_reg[`MIC_C1_RELF], interrupt_flags_enables_second_reg[`MIC_C1_BUFF], interrupt_flags_enables_second_reg[`MIC_C1_TICKF]} <= flags_next[4:2];
    end
  end

  // Take sequencer: one-cycle take pulse, then one cycle in ST_TAKEN before ST_RUN, whatever core_irq_ready does
  always @* begin
    case (state_reg)
      ST_RUN: state_next = take_now ? ST_TAKEN : ST_RUN;
      ST_TAKEN: state_next = ST_RUN;
      default: state_next = ST_RUN;
    endcase
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_reg <= ST_RUN;
      irq_take <= 1'b0;
      irq_vector <= 12'h000;
      irq_push_pc <= 12'h000;
      resume_pc <= 12'h000;
      resume_valid <= 1'b0;
    end else begin
      state_reg <= state_next;
      irq_take <= take_now;
      if (take_now) begin
        irq_vector <= vector_of(grant);
        irq_push_pc <= core_next_pc;
      end
      resume_valid <= return_from_irq_instr;
      if (return_from_irq_instr) begin
        resume_pc <= stack_pop_pc;
      end
    end
  end

  // Wake on any flag rising while asleep; a flag already set gives none
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      flags_q_reg <= 5'h00;
      wake_up <= 1'b0;
    end else begin
      flags_q_reg <= flags;
      wake_up <= sleep_mode && ((flags & ~flags_q_reg) != 5'h00);
    end
  end

endmodule

// >>> test/mic_irq_props.sv
// Port checker for the interrupt controller
`timescale 1ns/10ps
module mic_irq_props (
  // Clock and reset
  input wire hclk,
  input wire hresetn,
  // Pin and core side
  input wire ext_pin_pullhigh_sel,
  input wire ext_pin_pullhigh_en,
  input wire [11:0] core_next_pc,
  input wire core_irq_ready,
  input wire stack_full,
  input wire return_from_irq_instr,
  input wire [11:0] stack_pop_pc,
  input wire sleep_mode,
  input wire irq_take,
  input wire [11:0] irq_vector,
  input wire [11:0] irq_push_pc,
  input wire [11:0] resume_pc,
  input wire resume_valid,
  input wire wake_up
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  chk_take_spaced: assert property (irq_take |=> !irq_take)
    else $error("take repeated in next cycle");
  chk_vector_legal: assert property (irq_take |-> irq_vector inside {12'h004, 12'h008, 12'h00C, 12'h010, 12'h014})
    else $error("take with unknown vector");
  chk_full_blocks: assert property (irq_take |-> !$past(stack_full) && $past(core_irq_ready))
    else $error("take while stack full or core busy");
  chk_push_pc: assert property (irq_take |-> irq_push_pc == $past(core_next_pc))
    else $error("pushed address differs from next pc");
  chk_resume_pc: assert property (return_from_irq_instr |=> resume_valid && resume_pc == $past(stack_pop_pc))
    else $error("return did not resume at popped pc");
  chk_resume_cause: assert property (resume_valid |-> $past(return_from_irq_instr))
    else $error("resume without return");
  chk_pull_kept: assert property (ext_pin_pullhigh_en == ext_pin_pullhigh_sel)
    else $error("pull-high selection lost");
  chk_wake_sleep: assert property (wake_up |-> $past(sleep_mode))
    else $error("wake pulse outside sleep");
endmodule
bind mic_irq_ctrl mic_irq_props i_props (.hclk, .hresetn, .ext_pin_pullhigh_sel, .ext_pin_pullhigh_en,
  .core_next_pc, .core_irq_ready, .stack_full, .return_from_irq_instr, .stack_pop_pc, .sleep_mode,
  .irq_take, .irq_vector, .irq_push_pc, .resume_pc, .resume_valid, .wake_up);

// >>> test/mic_core_model.sv
// Core sequencer model: return stack pushed on take, popped on return
`timescale 1ns/10ps
module mic_core_model #(parameter DEPTH = 2) (
  // Clock and reset
  input wire hclk,
  input wire hresetn,
  // Controller side
  input wire irq_take,
  input wire [11:0] irq_push_pc,
  output wire stack_full,
  output reg return_from_irq_instr,
  output reg [11:0] stack_pop_pc,
  // Bench command
  input wire ret
);
  reg [11:0] stk [0:DEPTH-1];
  integer sp = 0;
  assign stack_full = sp == DEPTH;
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sp <= 0;
      return_from_irq_instr <= 1'h0;
      stack_pop_pc <= 12'h000;
    end else begin
      return_from_irq_instr <= ret && sp > 0;
      // Popped value only holds for its own cycle
      stack_pop_pc <= ~stack_pop_pc;
      if (ret && sp > 0) begin
        stack_pop_pc <= stk[sp-1];
        sp <= sp - 1;
      end else if (irq_take && sp < DEPTH) begin
        stk[sp] <= irq_push_pc;
        sp <= sp + 1;
      end
    end
  end
endmodule

// >>> test/test_mic_irq_ctrl.sv
// Self-checking bench for the interrupt controller
`timescale 1ns/10ps
`include "mic_map.vh"
module test_mic_irq_ctrl;
  reg hclk = 1'h0, hresetn = 1'h0, hsel = 1'h0, hwrite = 1'h0, ret = 1'h0, rd_phase = 1'h0;
  reg ext_pin_in = 1'h0, ext_pin_pullhigh_sel = 1'h0, sub_clock_tick = 1'h0, core_irq_ready = 1'h0;
  reg sleep_mode = 1'h0;
  reg [7:0] haddr = 8'h00;
  reg [1:0] htrans = 2'h0;
  reg [31:0] hwdata = 32'h0, r;
  reg [11:0] core_next_pc = 12'h000;
  reg [2:0] ev = 3'h0;
  wire counter_overflow = ev[0], buf_empty_event = ev[1], reload_done_event = ev[2];
  wire hreadyout, hresp, ext_pin_pullhigh_en, stack_full, return_from_irq_instr, irq_take, resume_valid, wake_up;
  wire [31:0] hrdata;
  wire [11:0] stack_pop_pc, irq_vector, irq_push_pc, resume_pc;
  integer seed = 18, fail_count = 0, checks = 0, wakes = 0, i;
  reg [31:0] exp_q[$];
  mic_irq_ctrl i_dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
    .hready(hreadyout), .hreadyout, .hresp, .hrdata, .ext_pin_in, .ext_pin_pullhigh_sel, .ext_pin_pullhigh_en,
    .counter_overflow, .buf_empty_event, .reload_done_event, .sub_clock_tick, .core_irq_ready, .core_next_pc,
    .stack_full, .return_from_irq_instr, .stack_pop_pc, .sleep_mode, .irq_take, .irq_vector, .irq_push_pc,
    .resume_pc, .resume_valid, .wake_up);
  mic_core_model #(.DEPTH(2)) i_core (.hclk, .hresetn, .irq_take, .irq_push_pc, .stack_full,
    .return_from_irq_instr, .stack_pop_pc, .ret);
  initial forever #10 hclk = ~hclk;
  task check(input [31:0] seen, input [31:0] want, input [8*8:1] what);
    begin
      checks = checks + 1;
      if (seen !== want) begin
        fail_count = fail_count + 1;
        $display("unexpected %0s expected %h seen %h", what, want, seen);
      end
    end
  endtask
  task give_verdict;
    begin
      $display("checks %0d fail_count %0d", checks, fail_count);
      if (fail_count == 0 && checks > 0)
        $display("ALL CHECKS OK");
      else
        $display("CHECKS NOT OK");
      $finish;
    end
  endtask
  task tick(input integer n);
    repeat (n) @(posedge hclk);
  endtask
  task wait_rdy;
    integer n;
    begin
      n = 0;
      @(posedge hclk);
      while (hreadyout !== 1'h1) begin
        n = n + 1;
        if (n > 99) begin
          fail_count = fail_count + 1;
          give_verdict;
        end
        @(posedge hclk);
      end
    end
  endtask
  // Write d, or read and note d as the expected word
  task xfer(input w, input [7:0] a, input [31:0] d);
    begin
      hsel <= 1'h1;
      haddr <= a;
      htrans <= 2'h2;
      hwrite <= w;
      wait_rdy;
      htrans <= 2'h0;
      hsel <= 1'h0;
      rd_phase <= !w;
      hwdata <= d;
      if (!w) exp_q.push_back(d);
      wait_rdy;
      rd_phase <= 1'h0;
    end
  endtask
  task pulse(input [2:0] m);
    begin
      ev <= m;
      tick(1);
      ev <= 3'h0;
      tick(1);
    end
  endtask
  task ret_pulse;
    begin
      ret <= 1'h1;
      tick(1);
      ret <= 1'h0;
      tick(1);
    end
  endtask
  task wait_take;
    integer n;
    begin
      n = 0;
      @(negedge hclk);
      while (irq_take !== 1'h1) begin
        n = n + 1;
        if (n > 199) begin
          fail_count = fail_count + 1;
          give_verdict;
        end
        @(negedge hclk);
      end
      @(posedge hclk);
    end
  endtask
  function automatic [31:0] pop_exp();
    pop_exp = exp_q.size() ? exp_q.pop_front() : 32'hFFFFFFFF;
  endfunction
  // Random core timing, next pc and pull-high choice
  always @(posedge hclk) begin
    r = $random(seed);
    core_next_pc <= r[11:0];
    core_irq_ready <= |r[13:12];
    ext_pin_pullhigh_sel <= r[14];
  end
  always @(posedge hclk) begin
    if (rd_phase) check(hrdata, pop_exp(), "rdata");
    if (irq_take) check({20'h0, irq_vector}, pop_exp(), "vector");
    if (wake_up) wakes = wakes + 1;
  end
  initial begin
    #2000000;
    fail_count = fail_count + 1;
    give_verdict;
  end
  initial begin
    tick(3);
    hresetn <= 1'h1;
    for (i = 0; i < 6; i = i + 1) xfer(1'h0, {i[5:0], 2'h0}, (i == 4) ? 32'h1 : 32'h0);
    xfer(1'h1, `MIC_OFS_INTERRUPT_FLAGS_ENABLES_SECOND, 32'hFF);
    xfer(1'h0, `MIC_OFS_INTERRUPT_FLAGS_ENABLES_SECOND, 32'h77);
    xfer(1'h1, `MIC_OFS_TBC, 32'hFF);
    xfer(1'h0, `MIC_OFS_TBC, 32'h87);
    xfer(1'h1, `MIC_OFS_INTERRUPT_FLAGS_ENABLES_FIRST, 32'hFE);
    xfer(1'h0, `MIC_OFS_INTERRUPT_FLAGS_ENABLES_FIRST, 32'h5A);
    tick(20);
    for (i = 1; i < 6; i = i + 1) exp_q.push_back(i * 4);
    xfer(1'h1, `MIC_OFS_INTERRUPT_FLAGS_ENABLES_FIRST, 32'hFF);
    for (i = 0; i < 5; i = i + 1) begin
      wait_take;
      tick(5);
      ret_pulse;
    end
    xfer(1'h0, `MIC_OFS_INTERRUPT_FLAGS_ENABLES_FIRST, 32'h0B);
    for (i = 0; i < 2; i = i + 1) begin
      exp_q.push_back(32'h8);
      pulse(3'h1);
      wait_take;
      xfer(1'h1, `MIC_OFS_INTERRUPT_FLAGS_ENABLES_FIRST, 32'h0B);
    end
    pulse(3'h1);
    tick(20);
    exp_q.push_back(32'h8);
    ret_pulse;
    wait_take;
    ret_pulse;
    ret_pulse;
    xfer(1'h1, `MIC_OFS_INTERRUPT_FLAGS_ENABLES_FIRST, 32'h0);
    xfer(1'h1, `MIC_OFS_INTERRUPT_FLAGS_ENABLES_SECOND, 32'h0);
    pulse(3'h1);
    pulse(3'h2);
    pulse(3'h4);
    xfer(1'h0, `MIC_OFS_INTERRUPT_FLAGS_ENABLES_FIRST, 32'h40);
    xfer(1'h0, `MIC_OFS_INTERRUPT_FLAGS_ENABLES_SECOND, 32'h60);
    for (i = 0; i < 4; i = i + 1) begin
      xfer(1'h1, `MIC_OFS_EDGE, i);
      xfer(1'h1, `MIC_OFS_INTERRUPT_FLAGS_ENABLES_FIRST, 32'h02);
      ext_pin_in <= 1'h1;
      tick(3);
      xfer(1'h0, `MIC_OFS_INTERRUPT_FLAGS_ENABLES_FIRST, {27'h0, i[0], 4'h2});
      xfer(1'h1, `MIC_OFS_INTERRUPT_FLAGS_ENABLES_FIRST, 32'h02);
      ext_pin_in <= 1'h0;
      tick(3);
      xfer(1'h0, `MIC_OFS_INTERRUPT_FLAGS_ENABLES_FIRST, {27'h0, i[1], 4'h2});
    end
    xfer(1'h1, `MIC_OFS_INTERRUPT_FLAGS_ENABLES_FIRST, 32'h0);
    ext_pin_in <= 1'h1;
    tick(3);
    xfer(1'h0, `MIC_OFS_INTERRUPT_FLAGS_ENABLES_FIRST, 32'h0);
    xfer(1'h1, `MIC_OFS_INTERRUPT_FLAGS_ENABLES_SECOND, 32'h0);
    sleep_mode <= 1'h1;
    tick(3);
    pulse(3'h2);
    pulse(3'h2);
    tick(4);
    sleep_mode <= 1'h0;
    check(wakes, 32'h1, "wakes");
    xfer(1'h1, `MIC_OFS_TBC, 32'h0);
    xfer(1'h1, `MIC_OFS_INTERRUPT_FLAGS_ENABLES_SECOND, 32'h0);
    xfer(1'h1, `MIC_OFS_TBC, 32'h81);
    tick(950);
    xfer(1'h0, `MIC_OFS_INTERRUPT_FLAGS_ENABLES_SECOND, 32'h0);
    tick(150);
    xfer(1'h0, `MIC_OFS_INTERRUPT_FLAGS_ENABLES_SECOND, 32'h10);
    xfer(1'h1, `MIC_OFS_STAT, 32'h100);
    xfer(1'h1, `MIC_OFS_TBC, 32'h0);
    xfer(1'h1, `MIC_OFS_INTERRUPT_FLAGS_ENABLES_SECOND, 32'h0);
    xfer(1'h1, `MIC_OFS_TBC, 32'h80);
    tick(600);
    xfer(1'h0, `MIC_OFS_INTERRUPT_FLAGS_ENABLES_SECOND, 32'h0);
    sub_clock_tick <= 1'h1;
    tick(600);
    xfer(1'h0, `MIC_OFS_INTERRUPT_FLAGS_ENABLES_SECOND, 32'h10);
    give_verdict;
  end
endmodule
